// [logic/ustx_pkg.sv]
// Constants, field layout and state types of the serial engine.
// Assumes an APB slave with 32-bit data and byte addresses.
package ustx_pkg;
   // ***********************
   // Register map
   // ***********************
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_MODE = 8'h04;
   localparam logic [7:0] ADDR_CMD = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0c;
   localparam logic [7:0] ADDR_SYNC = 8'h10;
   localparam int MODE_DIV = 0;
   localparam int MODE_LEN = 2;
   localparam int MODE_PAR_EN = 4;
   localparam int MODE_PAR_EVEN = 5;
   localparam int MODE_STOP = 6;
   localparam int MODE_SYNC = 8;
   localparam logic [8:0] MODE_RESET = 9'h04e;
   localparam int CMD_TRANSMIT_ENABLE_CONTROL = 0;
   localparam int CMD_RECEIVE_ENABLE_CONTROL = 1;
   localparam int CMD_BRK = 2;
   localparam int CMD_ECL = 3;
   localparam logic [2:0] CMD_RESET = 3'h0;
   localparam logic [7:0] SYNC_RESET = 8'h16;
   localparam logic [3:0] LNK_RESET = 4'hc;
   // ***********************
   // Clock factors and widths
   // ***********************
   localparam logic [1:0] DIV_X16 = 2'h2;
   localparam logic [1:0] DIV_X64 = 2'h3;
   localparam logic [6:0] RATE_X1 = 7'h01;
   localparam logic [6:0] RATE_X16 = 7'h10;
   localparam logic [6:0] RATE_X64 = 7'h40;
   localparam logic [3:0] MIN_BITS = 4'h5;
   localparam logic [3:0] MAX_BITS = 4'h8;
   localparam logic [3:0] RXSH_LEN = 4'h9;
   localparam logic [3:0] FRAME_EXTRA = 4'h2;
   localparam int CNT_W = 12;

   typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_BITS = 2'b01, TX_STOP = 2'b10} ustx_txst_t;
   typedef enum logic [2:0] {RX_OFF = 3'b000, RX_IDLE = 3'b001, RX_HUNT = 3'b010,
                             RX_START = 3'b011, RX_BITS = 3'b100, RX_STOP = 3'b101} ustx_rxst_t;

   function automatic logic [6:0] ustx_div(input logic [1:0] f);
      ustx_div = (f == DIV_X64) ? RATE_X64 : (f == DIV_X16) ? RATE_X16 : RATE_X1;
   endfunction : ustx_div

   function automatic logic [7:0] ustx_mask(input logic [3:0] n);
      ustx_mask = 8'hff >> (MAX_BITS - n);
   endfunction : ustx_mask
endpackage : ustx_pkg

// [logic/ustx_engine.sv]
// Serial transmit and receive engine with APB register access.
// Assumes link clocks, serial input and clear-to-send are asynchronous pins.
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
// Notes on behaviour
// - Serial output stays high when nothing is being shifted and send-break is off.
// - Async: written character moves to shifter, framed by start and stop bits.
// - Parity bit sits after last character bit, before stop.
// - Async output changes on divided falling edge of transmit clock.
// - Send-break forces serial output low at all times.
// - Receiver idles high, starts qualifying on a falling edge.
// - x16/x64: resample at half bit; still low accepts start.
// - Bit counter sets sample points; x1 samples on receive clock rise.
// - x16/x64: each bit sampled at its centre in receive clocks.
// - Receive ready set on buffer load, cleared on CPU read.
// - After stop sample receiver waits for next start bit.
// - Low stop bit sets framing error; reception continues normally.
// - Parity mismatch sets parity error flag.
// - Unread character overwritten by new one sets overrun.
// - Error flags never stop or alter transfers.
// - Input low beyond two frames raises break indication.
// - Start detection waits for enable and more than one bit high.
// - Sync mode: output high until first character written.
// - Sync: one bit per transmit clock fall, only with clear-to-send low.
// - Sync characters have no start or stop, optional parity.
// - Sync underrun raises drained and fills with sync characters.
// - Write during fill clears drained, sent after current sync character.
// - Disabling transmit finishes written characters, then idles high.
// - Error-clear command resets framing, overrun and parity flags.
module ustx_engine
   import ustx_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serialInLine,
   input wire logic transmitBitClock,
   input wire logic receiveBitClock,
   input wire logic clearToSendN,
   output logic serialOutLine,
   output logic receiveCharReady,
   output logic transmitHoldingFree,
   output logic transmitterDrained,
   output logic syncOrBreakIndication
);
   // ***********************
   // Pin synchronisers
   // ***********************
   logic [3:0] lnkMeta_r, lnkSync_r;
   logic [1:0] lnkDly_r;
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         lnkMeta_r <= LNK_RESET;
         lnkSync_r <= LNK_RESET;
         lnkDly_r <= '0;
      end else begin
         lnkMeta_r <= {clearToSendN, serialInLine, receiveBitClock, transmitBitClock};
         lnkSync_r <= lnkMeta_r;
         lnkDly_r <= lnkSync_r[1:0];
      end
   end
   wire txFall = lnkDly_r[0] & ~lnkSync_r[0];
   wire rxTick = ~lnkDly_r[1] & lnkSync_r[1];
   wire rxIn = lnkSync_r[2];
   wire ctsLow = ~lnkSync_r[3];

   // ***********************
   // APB slave and registers
   // ***********************
   logic [8:0] modeR_r;
   logic [2:0] cmdR_r;
   logic [7:0] syncChar_r, txHold_r, serial_in_line_r;
   logic txHoldFull_r, rxReady_r, parErr_r, overrun_r, framing_r, brkInd_r;
   logic txEmpty, rxReady_nxt, brkInd_nxt;
   logic [31:0] rdMux;
   wire setupPh = psel & ~penable;
   wire accessPh = psel & penable & pready;
   wire mapped = (paddr == ADDR_DATA) || (paddr == ADDR_MODE) || (paddr == ADDR_CMD)
                 || (paddr == ADDR_STAT) || (paddr == ADDR_SYNC);
   wire dataWr = accessPh & pwrite & (paddr == ADDR_DATA);
   wire dataRd = accessPh & ~pwrite & (paddr == ADDR_DATA);
   wire eclWr = accessPh & pwrite & (paddr == ADDR_CMD) & pwdata[CMD_ECL];
   wire asyncMode = ~modeR_r[MODE_SYNC];
   wire parEn = modeR_r[MODE_PAR_EN];
   wire parEven = modeR_r[MODE_PAR_EVEN];
   wire cmdTxEn = cmdR_r[CMD_TRANSMIT_ENABLE_CONTROL];
   wire cmdRxEn = cmdR_r[CMD_RECEIVE_ENABLE_CONTROL];
   wire cmdBrk = cmdR_r[CMD_BRK];
   wire [6:0] divSel = ustx_div(modeR_r[MODE_DIV +: 2]);
   wire [3:0] nBits = MIN_BITS + {2'h0, modeR_r[MODE_LEN +: 2]};
   wire [7:0] chMask = ustx_mask(nBits);

   always_comb begin
      case (paddr)
         ADDR_DATA: rdMux = 32'(serial_in_line_r);
         ADDR_MODE: rdMux = 32'(modeR_r);
         ADDR_CMD: rdMux = 32'(cmdR_r);
         ADDR_STAT: rdMux = 32'({brkInd_r, framing_r, overrun_r, parErr_r, txEmpty, rxReady_r, ~txHoldFull_r});
         ADDR_SYNC: rdMux = 32'(syncChar_r);
         default: rdMux = '0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= setupPh;
         pslverr <= setupPh & ~mapped;
         if (setupPh) begin
            prdata <= pwrite ? '0 : rdMux;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         modeR_r <= MODE_RESET;
         cmdR_r <= CMD_RESET;
         syncChar_r <= SYNC_RESET;
      end else if (accessPh & pwrite) begin
         if (paddr == ADDR_MODE) begin
            modeR_r <= pwdata[8:0];
         end
         if (paddr == ADDR_CMD) begin
            cmdR_r <= {pwdata[CMD_BRK], pwdata[CMD_RECEIVE_ENABLE_CONTROL], pwdata[CMD_TRANSMIT_ENABLE_CONTROL]};
         end
         if (paddr == ADDR_SYNC) begin
            syncChar_r <= pwdata[7:0];
         end
      end
   end

   // ***********************
   // Transmitter
   // ***********************
   ustx_txst_t txState_r;
   logic [CNT_W-1:0] txCnt_r;
   logic [9:0] txShift_r;
   logic [3:0] txLeft_r;
   logic syncStarted_r, fillActive_r;
   wire txStep = txFall & (asyncMode | ctsLow);
   wire [CNT_W-1:0] txDiv = asyncMode ? CNT_W'(divSel) : CNT_W'(RATE_X1);
   wire [CNT_W-1:0] stopRaw = CNT_W'(({5'h00, divSel} * {9'h000, {1'b0, modeR_r[MODE_STOP +: 2]} + 3'h1}) >> 1);
   wire [CNT_W-1:0] stopLen = (stopRaw == '0) ? CNT_W'(RATE_X1) : stopRaw;
   wire [CNT_W-1:0] txBitLen = (txState_r == TX_STOP) ? stopLen : txDiv;
   wire txBitEnd = txStep && (txCnt_r == txBitLen - CNT_W'(1));
   wire charEnd = txBitEnd && ((txState_r == TX_STOP) || (txState_r == TX_BITS && txLeft_r == 4'h1 && !asyncMode));
   wire canLoad = (txState_r == TX_IDLE && txStep) || charEnd;
   wire loadHold = canLoad & txHoldFull_r;
   wire loadFill = canLoad & ~txHoldFull_r & ~asyncMode & syncStarted_r & cmdTxEn;
   wire [7:0] txChar = (loadHold ? txHold_r : syncChar_r) & chMask;
   wire txPar = parEn & (^txChar ^ ~parEven);
   wire [9:0] txBody = 10'(txChar) | (10'(txPar) << nBits);
   assign txEmpty = ~txHoldFull_r & (txState_r == TX_IDLE || fillActive_r);

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         txState_r <= TX_IDLE;
         txCnt_r <= '0;
         txShift_r <= '0;
         txLeft_r <= '0;
      end else begin
         case (txState_r)
            TX_IDLE: txCnt_r <= '0;
            TX_BITS: begin
               if (txBitEnd) begin
                  txCnt_r <= '0;
                  txShift_r <= txShift_r >> 1;
                  txLeft_r <= txLeft_r - 4'h1;
                  if (txLeft_r == 4'h1) begin
                     txState_r <= asyncMode ? TX_STOP : TX_IDLE;
                  end
               end else if (txStep) begin
                  txCnt_r <= txCnt_r + CNT_W'(1);
               end
            end
            TX_STOP: begin
               if (txBitEnd) begin
                  txCnt_r <= '0;
                  txState_r <= TX_IDLE;
               end else if (txStep) begin
                  txCnt_r <= txCnt_r + CNT_W'(1);
               end
            end
            default: txState_r <= TX_IDLE;
         endcase
         if (loadHold | loadFill) begin
            txState_r <= TX_BITS;
            txCnt_r <= '0;
            txShift_r <= asyncMode ? {txBody[8:0], 1'b0} : txBody;
            txLeft_r <= nBits + {3'h0, parEn} + {3'h0, asyncMode};
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         txHoldFull_r <= 1'b0;
         txHold_r <= '0;
         syncStarted_r <= 1'b0;
         fillActive_r <= 1'b0;
         serialOutLine <= 1'b1;
         transmitHoldingFree <= 1'b0;
         transmitterDrained <= 1'b1;
      end else begin
         txHoldFull_r <= dataWr | (txHoldFull_r & ~loadHold);
         if (dataWr) begin
            txHold_r <= pwdata[7:0];
         end
         if (asyncMode || (!cmdTxEn && txState_r == TX_IDLE && !txHoldFull_r)) begin
            syncStarted_r <= 1'b0;
         end else if (loadHold) begin
            syncStarted_r <= 1'b1;
         end
         fillActive_r <= loadFill | (fillActive_r & ~loadHold);
         serialOutLine <= cmdBrk ? 1'b0 : (txState_r == TX_BITS) ? txShift_r[0] : 1'b1;
         transmitHoldingFree <= ~txHoldFull_r & ctsLow & cmdTxEn;
         transmitterDrained <= txEmpty;
      end
   end

   // ***********************
   // Receiver
   // ***********************
   ustx_rxst_t rxState_r;
   logic [CNT_W-1:0] rxCnt_r, brkCnt_r;
   logic [8:0] rxShift_r;
   logic [3:0] rxLeft_r;
   logic rxPrev_r;
   wire [CNT_W-1:0] rxDiv = CNT_W'(divSel);
   wire [CNT_W-1:0] rxWait = (rxState_r == RX_START) ? (rxDiv >> 1) : rxDiv;
   wire rxAt = rxTick && (rxCnt_r == rxWait - CNT_W'(1));
   wire [3:0] frameBits = nBits + {3'h0, parEn};
   wire [CNT_W-1:0] brkLimit = CNT_W'(({5'h00, divSel} * {8'h00, frameBits + FRAME_EXTRA}) << 1);
   wire brkHit = rxTick && !rxIn && cmdRxEn && (brkCnt_r == brkLimit);
   wire rxLoad = cmdRxEn && rxState_r == RX_STOP && rxAt;
   wire [8:0] rxAligned = rxShift_r >> (RXSH_LEN - frameBits);
   wire [7:0] rxChar = rxAligned[7:0] & chMask;
   wire peNow = parEn & (^rxChar ^ rxAligned[nBits] ^ ~parEven);

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rxState_r <= RX_OFF;
         rxCnt_r <= '0;
         rxShift_r <= '0;
         rxLeft_r <= '0;
         rxPrev_r <= 1'b1;
      end else begin
         if (rxTick) begin
            rxPrev_r <= rxIn;
         end
         if (!cmdRxEn) begin
            rxState_r <= RX_OFF;
         end else if (brkHit) begin
            rxState_r <= RX_IDLE;
            rxCnt_r <= '0;
         end else begin
            case (rxState_r)
               RX_OFF: begin
                  rxState_r <= RX_IDLE;
                  rxCnt_r <= '0;
               end
               RX_IDLE: if (rxTick) begin
                  if (!rxIn) begin
                     rxCnt_r <= '0;
                  end else if (rxCnt_r == rxDiv) begin
                     rxState_r <= RX_HUNT;
                     rxCnt_r <= '0;
                  end else begin
                     rxCnt_r <= rxCnt_r + CNT_W'(1);
                  end
               end
               RX_HUNT: if (rxTick && rxPrev_r && !rxIn) begin
                  rxCnt_r <= '0;
                  rxLeft_r <= frameBits;
                  rxState_r <= (divSel == RATE_X1) ? RX_BITS : RX_START;
               end
               RX_START: begin
                  if (rxAt) begin
                     rxCnt_r <= '0;
                     rxState_r <= rxIn ? RX_HUNT : RX_BITS;
                  end else if (rxTick) begin
                     rxCnt_r <= rxCnt_r + CNT_W'(1);
                  end
               end
               RX_BITS: begin
                  if (rxAt) begin
                     rxCnt_r <= '0;
                     rxShift_r <= {rxIn, rxShift_r[8:1]};
                     rxLeft_r <= rxLeft_r - 4'h1;
                     if (rxLeft_r == 4'h1) begin
                        rxState_r <= RX_STOP;
                     end
                  end else if (rxTick) begin
                     rxCnt_r <= rxCnt_r + CNT_W'(1);
                  end
               end
               RX_STOP: begin
                  if (rxAt) begin
                     rxCnt_r <= '0;
                     rxState_r <= RX_HUNT;
                  end else if (rxTick) begin
                     rxCnt_r <= rxCnt_r + CNT_W'(1);
                  end
               end
               default: rxState_r <= RX_OFF;
            endcase
         end
      end
   end

   assign rxReady_nxt = rxLoad | (rxReady_r & ~dataRd);
   assign brkInd_nxt = brkHit | (brkInd_r & ~rxIn & cmdRxEn);

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         brkCnt_r <= '0;
         serial_in_line_r <= '0;
         rxReady_r <= 1'b0;
         parErr_r <= 1'b0;
         overrun_r <= 1'b0;
         framing_r <= 1'b0;
         brkInd_r <= 1'b0;
         receiveCharReady <= 1'b0;
         syncOrBreakIndication <= 1'b0;
      end else begin
         if (!cmdRxEn || rxIn) begin
            brkCnt_r <= '0;
         end else if (rxTick && brkCnt_r != brkLimit) begin
            brkCnt_r <= brkCnt_r + CNT_W'(1);
         end
         if (rxLoad) begin
            serial_in_line_r <= rxChar;
         end
         rxReady_r <= rxReady_nxt;
         receiveCharReady <= rxReady_nxt;
         overrun_r <= (rxLoad & rxReady_r & ~dataRd) | (overrun_r & ~eclWr);
         parErr_r <= (rxLoad & peNow) | (parErr_r & ~eclWr);
         framing_r <= (rxLoad & ~rxIn) | (framing_r & ~eclWr);
         brkInd_r <= brkInd_nxt;
         syncOrBreakIndication <= brkInd_nxt;
      end
   end

   // ***********************
   // Checks
   // ***********************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   a_break_forces_low: assert property (cmdBrk |=> !serialOutLine)
      else $error("break did not force line low");
   a_idle_marks: assert property (txState_r == TX_IDLE && !cmdBrk |=> serialOutLine)
      else $error("idle line not marking");
   a_tx_fall_only: assert property (txState_r != $past(txState_r) |-> $past(txStep))
      else $error("transmit state moved off a clock fall");
   a_sync_cts_hold: assert property (!asyncMode && !ctsLow ##1 !asyncMode |-> $stable(txShift_r))
      else $error("sync shift without clear-to-send");
   a_start_reject: assert property (rxState_r == RX_START && rxAt && rxIn && cmdRxEn |=> rxState_r == RX_HUNT)
      else $error("high start sample accepted");
   a_ready_on_load: assert property (rxLoad |=> rxReady_r && receiveCharReady && serial_in_line_r == $past(rxChar))
      else $error("receive ready missing after load");
   a_overrun_flag: assert property (rxLoad && rxReady_r && !dataRd |=> overrun_r)
      else $error("overrun not flagged");
   a_framing_flag: assert property (rxLoad && !rxIn |=> framing_r && rxState_r == RX_HUNT)
      else $error("framing error handling wrong");
   a_error_clear: assert property (eclWr && !rxLoad |=> !parErr_r && !overrun_r && !framing_r)
      else $error("error flags survived clear");
   a_fill_drained: assert property (loadFill |=> ##1 transmitterDrained || txHoldFull_r)
      else $error("fill without drained indication");

   c_rx_char: cover property (rxLoad && !peNow && rxIn);
   c_sync_fill: cover property (loadFill ##[1:1000] loadHold);
   c_break: cover property (brkHit);
   c_overrun: cover property (rxLoad && rxReady_r);
endmodule : ustx_engine

// [test/ustx_line_peer.sv]
// Serial line peer: bit clocks, receive line driver, transmit line sampler.
// Assumes the engine samples every link pin with its own system clock.
`timescale 1ns/1ps
module ustx_line_peer (
   output logic transmitBitClock,
   output logic receiveBitClock,
   output logic serialInLine,
   output logic clearToSendN,
   input wire logic serialOutLine
);
   // ***********************
   // Baud clocks, 160 ns, unrelated in phase
   // ***********************
   initial begin
      transmitBitClock = 1'b1;
      receiveBitClock = 1'b1;
      serialInLine = 1'b1;
      clearToSendN = 1'b0;
      #3;
      forever #80 transmitBitClock = ~transmitBitClock;
   end
   initial begin
      #37;
      forever #80 receiveBitClock = ~receiveBitClock;
   end
   // ***********************
   // Line tasks
   // ***********************
   // Bit i of bits goes out i-th, fac receive clocks each
   task automatic send_bits(input logic [31:0] bits, input int n, input int fac);
      for (int i = 0; i < n; i++) begin
         @(negedge receiveBitClock);
         serialInLine = bits[i];
         repeat (fac - 1) @(negedge receiveBitClock);
      end
   endtask : send_bits
   // Waits for a low bit as bit 0, then samples n-1 more bits mid-bit
   task automatic capture(input int n, output logic [31:0] bits);
      int w;
      bits = 32'h0;
      w = 0;
      do begin
         @(posedge transmitBitClock);
         w++;
      end while (serialOutLine !== 1'b0 && w < 400);
      if (w >= 400) bits = 'x;
      for (int i = 1; i < n; i++) begin
         @(posedge transmitBitClock);
         bits[i] = serialOutLine;
      end
   endtask : capture
endmodule : ustx_line_peer

// [test/ustx_engine_tb.sv]
// Self-checking bench for the serial engine: APB master and scenarios.
// Assumes ustx_line_peer drives all link pins of the engine.
`timescale 1ns/1ps
module ustx_engine_tb
   import ustx_pkg::*;
;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd, cap;
   logic pready, pslverr, lastErr, serialInLine, transmitBitClock, receiveBitClock, clearToSendN;
   logic serialOutLine, receiveCharReady, transmitHoldingFree, transmitterDrained, syncOrBreakIndication;
   int badCount = 0;
   int cmpCount = 0;
   always #5 sys_clk = ~sys_clk;
   ustx_engine i_ustx_engine (.sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serialInLine(serialInLine), .transmitBitClock(transmitBitClock),
      .receiveBitClock(receiveBitClock), .clearToSendN(clearToSendN), .serialOutLine(serialOutLine),
      .receiveCharReady(receiveCharReady), .transmitHoldingFree(transmitHoldingFree),
      .transmitterDrained(transmitterDrained), .syncOrBreakIndication(syncOrBreakIndication));
   ustx_line_peer i_ustx_line_peer (.transmitBitClock(transmitBitClock), .receiveBitClock(receiveBitClock),
      .serialInLine(serialInLine), .clearToSendN(clearToSendN), .serialOutLine(serialOutLine));
   // ***********************
   // Shared tasks
   // ***********************
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmpCount, badCount);
      if (badCount == 0 && cmpCount > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         badCount++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         badCount++;
         print_verdict();
      end
   endtask : apb
   task automatic wait_ready();
      int n;
      n = 0;
      while (receiveCharReady !== 1'b1 && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 400) begin
         badCount++;
         print_verdict();
      end
   endtask : wait_ready
   // Two idle bits, start, 8 data, b9, b10, idle
   task automatic rx_frame(input logic [7:0] d, input logic b9, input logic b10);
      i_ustx_line_peer.send_bits({18'h0, 1'b1, b10, b9, d, 1'b0, 2'b11}, 14, 16);
   endtask : rx_frame
   // ***********************
   // Scenarios
   // ***********************
   task automatic t_reset();
      cmp({31'h0, serialOutLine}, 32'h1);
      apb(1'b0, ADDR_MODE, 32'h0);
      cmp(rd, {23'h0, MODE_RESET});
      apb(1'b0, ADDR_STAT, 32'h0);
      cmp(rd, 32'h5);
      apb(1'b0, 8'h14, 32'h0);
      cmp({rd[30:0], lastErr}, 32'h1);
   endtask : t_reset
   task automatic t_async_tx();
      apb(1'b1, ADDR_MODE, 32'h7d);
      apb(1'b1, ADDR_CMD, 32'h1);
      repeat (6) @(posedge sys_clk);
      cmp({31'h0, transmitHoldingFree}, 32'h1);
      apb(1'b1, ADDR_DATA, 32'ha5);
      i_ustx_line_peer.capture(11, cap);
      cmp(cap, {21'h0, 2'b10, 8'ha5, 1'b0});
      apb(1'b1, ADDR_CMD, 32'h5);
      repeat (6) @(posedge sys_clk);
      cmp({31'h0, serialOutLine}, 32'h0);
      apb(1'b1, ADDR_CMD, 32'h1);
      apb(1'b1, ADDR_DATA, 32'h3c);
      apb(1'b1, ADDR_CMD, 32'h0);
      i_ustx_line_peer.capture(11, cap);
      cmp(cap, {21'h0, 2'b10, 8'h3c, 1'b0});
      repeat (60) @(posedge sys_clk);
      cmp({31'h0, serialOutLine}, 32'h1);
      apb(1'b1, ADDR_MODE, 32'hd9);
      apb(1'b1, ADDR_CMD, 32'h1);
      apb(1'b1, ADDR_DATA, 32'h35);
      fork
         i_ustx_line_peer.capture(13, cap);
         begin
            repeat (40) @(posedge sys_clk);
            apb(1'b1, ADDR_DATA, 32'h1);
         end
      join
      cmp(cap, {19'h0, 5'b10111, 7'h35, 1'b0});
      repeat (200) @(posedge sys_clk);
   endtask : t_async_tx
   task automatic t_async_rx();
      apb(1'b1, ADDR_MODE, 32'h4e);
      apb(1'b1, ADDR_CMD, 32'ha);
      rx_frame(8'h96, 1'b1, 1'b1);
      wait_ready();
      apb(1'b0, ADDR_DATA, 32'h0);
      cmp(rd, 32'h96);
      repeat (3) @(posedge sys_clk);
      cmp({31'h0, receiveCharReady}, 32'h0);
      i_ustx_line_peer.send_bits(32'h6, 3, 4);
      rx_frame(8'h11, 1'b1, 1'b1);
      rx_frame(8'h22, 1'b0, 1'b1);
      apb(1'b0, ADDR_STAT, 32'h0);
      cmp(rd, 32'h37);
      apb(1'b0, ADDR_DATA, 32'h0);
      cmp(rd, 32'h22);
      apb(1'b1, ADDR_CMD, 32'ha);
      apb(1'b0, ADDR_STAT, 32'h0);
      cmp(rd, 32'h5);
      apb(1'b1, ADDR_MODE, 32'h7e);
      rx_frame(8'h01, 1'b0, 1'b1);
      wait_ready();
      apb(1'b0, ADDR_STAT, 32'h0);
      cmp(rd, 32'hf);
      apb(1'b0, ADDR_DATA, 32'h0);
      cmp(rd, 32'h1);
   endtask : t_async_rx
   task automatic t_rx_break();
      apb(1'b1, ADDR_CMD, 32'ha);
      i_ustx_line_peer.send_bits(32'h0, 20, 16);
      cmp({31'h0, syncOrBreakIndication}, 32'h0);
      i_ustx_line_peer.send_bits(32'h0, 4, 16);
      cmp({31'h0, syncOrBreakIndication}, 32'h1);
      i_ustx_line_peer.send_bits(32'h3, 2, 16);
      cmp({31'h0, syncOrBreakIndication}, 32'h0);
   endtask : t_rx_break
   task automatic t_sync_tx();
      apb(1'b1, ADDR_MODE, 32'h10c);
      apb(1'b1, ADDR_CMD, 32'h1);
      repeat (100) @(posedge sys_clk);
      cmp({31'h0, serialOutLine}, 32'h1);
      apb(1'b1, ADDR_DATA, 32'h5a);
      i_ustx_line_peer.capture(16, cap);
      cmp(cap, {16'h0, SYNC_RESET, 8'h5a});
      cmp({31'h0, transmitterDrained}, 32'h1);
      i_ustx_line_peer.clearToSendN = 1'b1;
      repeat (20) @(posedge sys_clk);
      cap[0] = serialOutLine;
      repeat (100) @(posedge sys_clk);
      cmp({31'h0, serialOutLine}, {31'h0, cap[0]});
      i_ustx_line_peer.clearToSendN = 1'b0;
      apb(1'b1, ADDR_DATA, 32'hc3);
      repeat (3) @(posedge sys_clk);
      cmp({31'h0, transmitterDrained}, 32'h0);
   endtask : t_sync_tx
   // ***********************
   // Main sequence and watchdog
   // ***********************
   initial begin
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_async_tx();
      t_async_rx();
      t_rx_break();
      t_sync_tx();
      print_verdict();
   end
   initial begin
      #1000000;
      badCount++;
      print_verdict();
   end
endmodule : ustx_engine_tb
